// *** hw/owg_pkg.sv ***
// Shared constants and types for the overlay window geometry block
package owg_pkg;
    // Register byte offsets
    localparam logic [7:0]  OWG_GDC_OFF     = 8'h10;
    localparam logic [7:0]  OWG_MWS_OFF     = 8'h44;
    localparam logic [7:0]  OWG_OSA_OFF     = 8'h50;
    localparam logic [7:0]  OWG_OST_OFF     = 8'h54;
    localparam logic [7:0]  OWG_OFA_OFF     = 8'h58;
    localparam logic [7:0]  OWG_OSX_OFF     = 8'h5c;
    localparam logic [7:0]  OWG_STAT_OFF    = 8'h60;
    localparam logic [7:0]  OWG_SIZE_OFF    = 8'h64;
    localparam int          OWG_PADDR_W     = 12;
    // Field positions
    localparam int          OWG_ENA_BIT     = 19;
    localparam int          OWG_ROT_BIT     = 16;
    localparam int          OWG_BPP_LSB     = 0;
    localparam int          OWG_BPP_W       = 3;
    localparam int          OWG_POS_W       = 10;
    localparam int          OWG_START_LSB   = 0;
    localparam int          OWG_END_LSB     = 16;
    // Values after reset and limits
    localparam logic [31:0] OWG_REG_RST     = 32'h0000_0000;
    localparam logic [2:0]  OWG_BPP_MAX     = 3'h4;
    localparam logic [2:0]  OWG_DWORD_SHIFT = 3'h5;
    localparam int          OWG_BUF_DEPTH   = 2;

    typedef enum logic [1:0] {
        OWG_IDLE = 2'b01,
        OWG_RUN  = 2'b10
    } owg_state_e;

    typedef struct packed {
        logic [31:0] addr;
        logic        line_end;
        logic        frame_end;
    } owg_fetch_s;

    typedef struct packed {
        logic [15:0] left;
        logic [15:0] right;
        logic [15:0] top;
        logic [15:0] bottom;
        logic [15:0] width;
        logic [15:0] height;
    } owg_geom_s;
endpackage : owg_pkg

// *** hw/owg_overlay_window.sv ***
// Overlay window geometry, fetch walker and APB register file
//
// Function
// [RULE1] Image start addresses are dword aligned
// [RULE2] Equal strides share one image
// [RULE3] First-axis register: start 9-0, end 25-16
// [RULE4] Second-axis register: start 9-0, end 25-16
// [RULE5] Overlay shown only while enable bit set
// [RULE6] Unrotated first axis: scaled left/right edges
// [RULE7] Unrotated second axis: top/bottom lines
// [RULE8] Rotated first axis: top/bottom lines
// [RULE9] Rotated second axis: mirrored scaled edges
// [RULE10] Size is end minus start plus one
// [RULE11] Start address is byte address over four
// [RULE12] Stride in dwords, added per line
// [RULE13] Rotation turns both images counter-clockwise
// [RULE14] Overlay image stored after main image
// [RULE15] Rotated start is last dword of line
`timescale 1ns/1ps
module owg_overlay_window #(
    parameter logic [15:0] PANEL_H = 16'd240
) (
    input  wire logic                                 pclk,
    input  wire logic                                 presetn,
    input  wire logic [owg_pkg::OWG_PADDR_W-1:0]      paddr,
    input  wire logic                                 psel,
    input  wire logic                                 penable,
    input  wire logic                                 pwrite,
    input  wire logic [31:0]                          pwdata,
    input  wire logic [3:0]                           pstrb,
    output logic      [31:0]                          prdata,
    output logic                                      pready,
    output logic                                      pslverr,
    input  wire logic                                 frame_start,
    output owg_pkg::owg_fetch_s                       fetch,
    output logic                                      fetch_valid,
    input  wire logic                                 fetch_ready,
    output owg_pkg::owg_geom_s                        geom,
    output logic                                      overlay_on,
    output logic                                      rotate90,
    output logic                                      busy
);
    import owg_pkg::*;

    typedef struct packed {
        // Software-visible registers
        logic                 ena;
        logic                 rot;
        logic [2:0]           bpp;
        logic [31:0]          main_stride;
        logic [31:0]          start_addr;
        logic [31:0]          ovl_stride;
        logic [9:0]           fa_s;
        logic [9:0]           fa_e;
        logic [9:0]           sa_s;
        logic [9:0]           sa_e;

        // Frame walker
        owg_state_e           fsm;
        logic                 walk_rot;
        logic [31:0]          line_base;
        logic [31:0]          cur;
        logic [9:0]           inner;
        logic [9:0]           outer;

        // Output buffer
        owg_fetch_s           b0;
        owg_fetch_s           b1;
        logic                 v0;
        logic                 v1;

        // Bus answer and registered outputs
        logic [31:0]          prdata;
        logic                 pready;
        logic                 pslverr;
        owg_geom_s            geom;
        logic                 busy;
    } owg_st_s;

    owg_st_s s;
    owg_st_s next_s;

    // Byte lanes without a strobe keep their old contents
    function automatic logic [31:0] owg_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  strb);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction : owg_merge

    // Pixels per dword as a shift: 32/bpp
    function automatic logic [15:0] owg_scale(input logic [10:0] pos,
                                              input logic [2:0]  sh);
        logic [15:0] r;
        r = {5'h0, pos} << sh;
        return r;
    endfunction : owg_scale

    function automatic logic [31:0] owg_gdc_word(input logic       ena,
                                                 input logic       rot,
                                                 input logic [2:0] bpp);
        logic [31:0] r;
        r = OWG_REG_RST;
        r[OWG_ENA_BIT] = ena;
        r[OWG_ROT_BIT] = rot;
        r[OWG_BPP_LSB +: OWG_BPP_W] = bpp;
        return r;
    endfunction : owg_gdc_word

    // Reserved bits read back as zero
    function automatic logic [31:0] owg_pos_word(input logic [9:0] st,
                                                 input logic [9:0] en);
        logic [31:0] r;
        r = OWG_REG_RST;
        r[OWG_START_LSB +: OWG_POS_W] = st;
        r[OWG_END_LSB +: OWG_POS_W]   = en;
        return r;
    endfunction : owg_pos_word

    // Axis extent minus one; end below start wraps modulo 1024
    function automatic logic [9:0] owg_diff(input logic [9:0] st,
                                            input logic [9:0] en);
        return en - st;
    endfunction : owg_diff

    // Scaled axis span; truncated fields shrink the window
    function automatic logic [15:0] owg_px_span(input logic [9:0] st,
                                                input logic [9:0] en,
                                                input logic [2:0] sh);
        return owg_scale({1'b0, owg_diff(st, en)} + 11'h1, sh);
    endfunction : owg_px_span

    function automatic logic [15:0] owg_ln_span(input logic [9:0] st,
                                                input logic [9:0] en);
        return {6'h0, owg_diff(st, en)} + 16'h1;
    endfunction : owg_ln_span

    // Rotation mirrors the second axis about the panel height
    function automatic logic [15:0] owg_mirror(input logic [10:0] pos,
                                               input logic [2:0]  sh);
        return PANEL_H - owg_scale(pos, sh);
    endfunction : owg_mirror

    logic [2:0]  bpp_c;
    logic [2:0]  sh;
    logic [7:0]  reg_off;
    logic        hit;
    logic [31:0] rd;
    logic [31:0] gdc_word;
    logic [31:0] wr_word;
    logic        wr_en;
    logic        push;
    logic        pop;
    logic        in_last;
    logic        out_last;
    owg_fetch_s  item;

    always_comb begin
        next_s   = s;
        // Unsupported depth codes fall back to the widest pixel
        bpp_c    = (s.bpp > OWG_BPP_MAX) ? OWG_BPP_MAX : s.bpp;
        sh       = OWG_DWORD_SHIFT - bpp_c;
        reg_off  = paddr[7:0];
        gdc_word = owg_gdc_word(s.ena, s.rot, s.bpp);

        // APB decode; upper address bits and misaligned words are unmapped
        hit = 1'b1;
        rd  = OWG_REG_RST;
        if (paddr[OWG_PADDR_W-1:8] != '0 || paddr[1:0] != 2'b00) begin
            hit = 1'b0;
        end else if (reg_off == OWG_GDC_OFF) begin
            rd = gdc_word;
        end else if (reg_off == OWG_MWS_OFF) begin
            rd = s.main_stride;
        end else if (reg_off == OWG_OSA_OFF) begin
            rd = s.start_addr;
        end else if (reg_off == OWG_OST_OFF) begin
            rd = s.ovl_stride;
        end else if (reg_off == OWG_OFA_OFF) begin
            rd = owg_pos_word(s.fa_s, s.fa_e); // RULE3
        end else if (reg_off == OWG_OSX_OFF) begin
            rd = owg_pos_word(s.sa_s, s.sa_e); // RULE4
        end else if (reg_off == OWG_STAT_OFF) begin
            rd[0] = s.ena;
            rd[1] = s.busy;
            rd[2] = s.v0;
            rd[3] = s.v1;
        end else if (reg_off == OWG_SIZE_OFF) begin
            rd[31:16] = s.geom.height;
            rd[15:0]  = s.geom.width;
        end else begin
            hit = 1'b0;
        end

        // Zero-wait slave: answer prepared in setup, shown in access
        next_s.pready  = psel && !penable;
        next_s.pslverr = psel && !penable && !hit;
        next_s.prdata  = (psel && !penable && !pwrite && hit) ? rd : OWG_REG_RST;

        wr_en = psel && penable && pwrite && s.pready && !s.pslverr;
        if (wr_en) begin
            if (reg_off == OWG_GDC_OFF) begin
                // A rotation change reaches the walker from the next frame start; rotate90 follows at once, geom one cycle later
                wr_word        = owg_merge(gdc_word, pwdata, pstrb);
                next_s.ena     = wr_word[OWG_ENA_BIT];
                next_s.rot     = wr_word[OWG_ROT_BIT];
                next_s.bpp     = wr_word[OWG_BPP_LSB +: OWG_BPP_W];
            end else if (reg_off == OWG_MWS_OFF) begin
                wr_word            = owg_merge(s.main_stride, pwdata, pstrb);
                next_s.main_stride = wr_word;
            end else if (reg_off == OWG_OSA_OFF) begin
                wr_word           = owg_merge(s.start_addr, pwdata, pstrb);
                next_s.start_addr = wr_word; // RULE11
            end else if (reg_off == OWG_OST_OFF) begin
                wr_word           = owg_merge(s.ovl_stride, pwdata, pstrb);
                next_s.ovl_stride = wr_word; // RULE12
            end else if (reg_off == OWG_OFA_OFF) begin
                wr_word     = owg_merge(owg_pos_word(s.fa_s, s.fa_e), pwdata, pstrb);
                next_s.fa_s = wr_word[OWG_START_LSB +: OWG_POS_W]; // RULE3
                next_s.fa_e = wr_word[OWG_END_LSB +: OWG_POS_W];   // RULE3
            end else if (reg_off == OWG_OSX_OFF) begin
                wr_word     = owg_merge(owg_pos_word(s.sa_s, s.sa_e), pwdata, pstrb);
                next_s.sa_s = wr_word[OWG_START_LSB +: OWG_POS_W]; // RULE4
                next_s.sa_e = wr_word[OWG_END_LSB +: OWG_POS_W];   // RULE4
            end else begin
                // Status and size are read-only; writes are dropped
                wr_word = OWG_REG_RST;
            end
        end else begin
            wr_word = OWG_REG_RST;
        end

        // Window rectangle on the panel and its true size after truncation
        if (s.rot) begin
            next_s.geom.top    = {6'h0, s.fa_s}; // RULE8
            next_s.geom.bottom = {6'h0, s.fa_e}; // RULE8
            next_s.geom.left   = owg_mirror({1'b0, s.sa_e} + 11'h1, sh); // RULE9
            next_s.geom.right  = owg_mirror({1'b0, s.sa_s}, sh) - 16'h1; // RULE9
            next_s.geom.width  = owg_px_span(s.sa_s, s.sa_e, sh); // RULE10
            next_s.geom.height = owg_ln_span(s.fa_s, s.fa_e); // RULE10
        end else begin
            next_s.geom.left   = owg_scale({1'b0, s.fa_s}, sh); // RULE6
            next_s.geom.right  = owg_scale({1'b0, s.fa_e} + 11'h1, sh) - 16'h1; // RULE6
            next_s.geom.top    = {6'h0, s.sa_s}; // RULE7
            next_s.geom.bottom = {6'h0, s.sa_e}; // RULE7
            next_s.geom.width  = owg_px_span(s.fa_s, s.fa_e, sh); // RULE10
            next_s.geom.height = owg_ln_span(s.sa_s, s.sa_e); // RULE10
        end

        // Walker: inner steps along the fetch line, outer moves to the next
        in_last  = s.inner == owg_diff(s.fa_s, s.fa_e);
        out_last = s.outer == owg_diff(s.sa_s, s.sa_e);
        item.addr      = s.cur;
        item.line_end  = in_last;
        item.frame_end = in_last && out_last;
        // Only a free second slot accepts; keeps full honest without bypass
        push = (s.fsm == OWG_RUN) && !s.v1;
        pop  = s.v0 && fetch_ready;

        case (s.fsm)
            OWG_IDLE: begin
                if (frame_start && s.ena) begin // RULE5
                    next_s.fsm       = OWG_RUN;
                    next_s.walk_rot  = s.rot; // RULE13
                    next_s.line_base = s.start_addr; // RULE1 RULE11 RULE15
                    next_s.cur       = s.start_addr;
                    next_s.inner     = 10'h0;
                    next_s.outer     = 10'h0;
                end
            end
            OWG_RUN: begin
                if (!s.ena) begin
                    // Dropping enable cuts the frame; queued words still drain
                    next_s.fsm = OWG_IDLE; // RULE5
                end else if (push) begin
                    if (!in_last) begin
                        next_s.inner = s.inner + 10'h1;
                        // Rotated: walk down a column; plain: next dword
                        next_s.cur   = s.walk_rot ? s.cur + s.ovl_stride // RULE13
                                                  : s.cur + 32'h1;
                    end else if (!out_last) begin
                        next_s.inner     = 10'h0;
                        next_s.outer     = s.outer + 10'h1;
                        // Rotated walk moves left one dword column
                        next_s.line_base = s.walk_rot ? s.line_base - 32'h1 // RULE15
                                                      : s.line_base + s.ovl_stride; // RULE12 RULE2
                        next_s.cur       = next_s.line_base;
                    end else begin
                        next_s.fsm = OWG_IDLE;
                    end
                end
            end
            default: begin
                next_s.fsm = OWG_IDLE;
            end
        endcase

        // Busy kept as its own flip-flop for the output
        next_s.busy = next_s.fsm == OWG_RUN;

        // Two-entry buffer; a receiver stall backs up into the walker
        if (pop) begin
            next_s.b0 = s.b1;
            next_s.v0 = s.v1;
            next_s.v1 = 1'b0;
        end
        if (push) begin
            if (!next_s.v0) begin
                next_s.b0 = item;
                next_s.v0 = 1'b1;
            end else begin
                next_s.b1 = item;
                next_s.v1 = 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s     <= '0;
            // One-hot idle code is not all zeros
            s.fsm <= OWG_IDLE;
        end else begin
            s <= next_s;
        end
    end

    assign prdata      = s.prdata;
    assign pready      = s.pready;
    assign pslverr     = s.pslverr;
    assign fetch       = s.b0;
    assign fetch_valid = s.v0;
    assign geom        = s.geom;
    assign overlay_on  = s.ena; // RULE5
    assign rotate90    = s.rot; // RULE13
    assign busy        = s.busy;
endmodule : owg_overlay_window

// *** tb/owg_overlay_window_properties.sv ***
// Port assertions for the overlay window block
`timescale 1ns/1ps
module owg_overlay_window_properties
    import owg_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic [11:0] paddr,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic        pready,
    input wire logic        frame_start,
    input wire owg_fetch_s  fetch,
    input wire logic        fetch_valid,
    input wire logic        fetch_ready,
    input wire owg_geom_s   geom,
    input wire logic        overlay_on,
    input wire logic        rotate90,
    input wire logic        busy
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic        wr_done;
    logic        acc;
    logic [31:0] prev_addr;
    logic        prev_le;
    logic        have_prev;
    assign wr_done = psel && penable && pready && pwrite && pstrb == 4'hf;
    assign acc = fetch_valid && fetch_ready;
    // Remembers the last accepted word to judge the next one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_addr <= 32'h0;
            prev_le <= 1'b0;
            have_prev <= 1'b0;
        end else if (acc) begin
            prev_addr <= fetch.addr;
            prev_le <= fetch.line_end;
            have_prev <= !fetch.frame_end;
        end
    end
    property p_ena; wr_done && paddr == 12'h010 |=> ##1 overlay_on == $past(pwdata[19], 2);
    endproperty
    a_ena: assert property (p_ena) else $error("enable bit not shown");
    property p_rot; wr_done && paddr == 12'h010 |=> ##1 rotate90 == $past(pwdata[16], 2);
    endproperty
    a_rot: assert property (p_rot) else $error("rotate bit not shown");
    property p_off; frame_start && !overlay_on && !busy |=> !busy; endproperty
    a_off: assert property (p_off) else $error("walk started while disabled");
    property p_go; frame_start && overlay_on && !busy && !fetch_valid |=> busy ##1 fetch_valid;
    endproperty
    a_go: assert property (p_go) else $error("walk did not start");
    property p_step; acc && have_prev && !prev_le && !rotate90 |-> fetch.addr == prev_addr + 32'h1;
    endproperty
    a_step: assert property (p_step) else $error("address step wrong");
    property p_fe; fetch_valid && fetch.frame_end |-> fetch.line_end; endproperty
    a_fe: assert property (p_fe) else $error("frame end without line end");
    property p_hold; fetch_valid && !fetch_ready |=> fetch_valid && $stable(fetch); endproperty
    a_hold: assert property (p_hold) else $error("stalled word changed");
    property p_hu; wr_done && paddr == 12'h05c && !rotate90 && pwdata[25:16] >= pwdata[9:0]
        |-> ##2 geom.height == 16'($past(pwdata[25:16], 2)) - 16'($past(pwdata[9:0], 2)) + 16'h1;
    endproperty
    a_hu: assert property (p_hu) else $error("unrotated height wrong");
    property p_hr; wr_done && paddr == 12'h058 && rotate90 && pwdata[25:16] >= pwdata[9:0]
        |-> ##2 geom.height == 16'($past(pwdata[25:16], 2)) - 16'($past(pwdata[9:0], 2)) + 16'h1;
    endproperty
    a_hr: assert property (p_hr) else $error("rotated height wrong");
endmodule : owg_overlay_window_properties

bind owg_overlay_window owg_overlay_window_properties u_props (.pclk, .presetn, .paddr, .psel,
    .penable, .pwrite, .pwdata, .pstrb, .pready, .frame_start, .fetch, .fetch_valid,
    .fetch_ready, .geom, .overlay_on, .rotate90, .busy);

// *** tb/owg_fetch_sink.sv ***
// Stall-capable consumer model for the fetch stream
`timescale 1ns/1ps
module owg_fetch_sink (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic hold,
    input  wire logic slow,
    output logic      fetch_ready
);
    logic [1:0] phase;
    // Slow mode takes one word in three so the buffer refills
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase <= 2'h0;
            fetch_ready <= 1'b0;
        end else begin
            phase <= (phase == 2'h2) ? 2'h0 : phase + 2'h1;
            fetch_ready <= !hold && (!slow || phase == 2'h0);
        end
    end
endmodule : owg_fetch_sink

// *** tb/test_overlay_window_geometry.sv ***
// Register and fetch stream tests for the overlay window block
`timescale 1ns/1ps
module test_overlay_window_geometry;
    import owg_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic        frame_start, fetch_valid, fetch_ready, overlay_on, rotate90, busy, hold, slow;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  pstrb;
    owg_fetch_s  fetch;
    owg_geom_s   geom;
    owg_fetch_s  got[$];
    int          failures, comparisons, ss, se;
    localparam logic [11:0] OWG_OFFS [6] = '{12'h010, 12'h044, 12'h050,
                                              12'h054, 12'h058, 12'h05c};
    owg_overlay_window #(.PANEL_H(16'd240)) dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .frame_start(frame_start),
        .fetch(fetch), .fetch_valid(fetch_valid), .fetch_ready(fetch_ready), .geom(geom),
        .overlay_on(overlay_on), .rotate90(rotate90), .busy(busy));
    owg_fetch_sink sink (.pclk(pclk), .presetn(presetn), .hold(hold), .slow(slow),
        .fetch_ready(fetch_ready));
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        if (fetch_valid === 1'b1 && fetch_ready === 1'b1) got.push_back(fetch);
    end
    task automatic final_report();
        if (failures == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : final_report
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // Idle cycle between transfers keeps each strobe change on its own edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 16; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n == 16) begin
            failures++;
            final_report();
        end
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask : rdchk
    function automatic logic [31:0] gdc(input logic ena, input logic rot);
        return (32'(ena) << OWG_ENA_BIT) | (32'(rot) << OWG_ROT_BIT) | 32'h2;
    endfunction : gdc
    task automatic pulse();
        @(posedge pclk);
        frame_start <= 1'b1;
        @(posedge pclk);
        frame_start <= 1'b0;
    endtask : pulse
    // Two lines of two words, consumer stalled until the buffer is full
    task automatic walk(input logic rot, input logic [31:0] start, input logic [31:0] stride);
        int n;
        int k;
        logic [31:0] a;
        got.delete();
        wr(12'h058, 32'h0001_0000);
        wr(12'h05c, 32'h0001_0000);
        wr(12'h050, start);
        wr(12'h054, stride);
        wr(12'h010, gdc(1'b1, rot));
        hold <= 1'b1;
        pulse();
        repeat (8) @(posedge pclk);
        apb(1'b0, 12'h060, 32'h0);
        chk({30'h0, rd[3:2]}, 32'h3);
        hold <= 1'b0;
        for (n = 0; n < 400 && got.size() < 4; n++) @(posedge pclk);
        chk(got.size(), 32'h4);
        if (got.size() < 4) final_report();
        for (k = 0; k < 4 && k < got.size(); k++) begin
            a = rot ? start - k / 2 + (k % 2) * stride : start + k % 2 + (k / 2) * stride;
            chk(got[k].addr, a);
            chk(32'({got[k].line_end, got[k].frame_end}), {30'h0, k % 2 == 1, k == 3});
        end
        repeat (4) @(posedge pclk);
        chk({31'h0, busy}, 32'h0);
    endtask : walk
    initial begin
        {presetn, psel, penable, pwrite, frame_start, hold} = 6'h0;
        slow = 1'b1;
        paddr = 12'h0;
        pwdata = 32'h0;
        pstrb = 4'hf;
        failures = 0;
        comparisons = 0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        foreach (OWG_OFFS[i]) rdchk(OWG_OFFS[i], 32'h0);
        wr(12'h058, 32'hffff_ffff);
        rdchk(12'h058, 32'h03ff_03ff);
        wr(12'h05c, 32'hffff_ffff);
        rdchk(12'h05c, 32'h03ff_03ff);
        wr(12'h044, 32'h14);
        wr(12'h054, 32'h14);
        rdchk(12'h044, 32'h14);
        rdchk(12'h054, 32'h14);
        wr(12'h050, 32'hffff_fffc);
        apb(1'b1, 12'h052, 32'h0);
        chk({31'h0, err}, 32'h1);
        rdchk(12'h050, 32'hffff_fffc);
        apb(1'b0, 12'h068, 32'h0);
        chk({31'h0, err}, 32'h1);
        chk(rd, 32'h0);
        wr(12'h010, gdc(1'b0, 1'b0));
        wr(12'h058, {6'h0, 10'(239 / 8), 6'h0, 10'(80 / 8)});
        wr(12'h05c, {6'h0, 10'd179, 6'h0, 10'd60});
        repeat (3) @(posedge pclk);
        chk({16'h0, geom.width}, (239 / 8 - 80 / 8 + 1) * 8);
        chk({16'h0, geom.height}, 179 - 60 + 1);
        chk({geom.left, geom.right}, {16'd80, 16'd239});
        chk({geom.top, geom.bottom}, {16'd60, 16'd179});
        rdchk(12'h064, {16'd120, 16'd160});
        wr(12'h010, 32'h7);
        repeat (3) @(posedge pclk);
        chk({16'h0, geom.width}, (239 / 8 - 80 / 8 + 1) * 2);
        ss = (240 - 179 - 1) / 8;
        se = (240 - 60 - 1) / 8;
        wr(12'h010, gdc(1'b0, 1'b1));
        wr(12'h058, {6'h0, 10'd239, 6'h0, 10'd80});
        wr(12'h05c, {6'h0, 10'(se), 6'h0, 10'(ss)});
        repeat (3) @(posedge pclk);
        chk({16'h0, geom.width}, (se - ss + 1) * 8);
        chk({16'h0, geom.height}, 239 - 80 + 1);
        chk({geom.top, geom.bottom}, {16'd80, 16'd239});
        chk({geom.left, geom.right}, {16'(240 - (se + 1) * 8), 16'(239 - ss * 8)});
        chk({31'h0, rotate90}, 32'h1);
        walk(1'b0, 32'h9600 / 4, 128 / 8);
        walk(1'b1, (32'h9600 + 64 + ((4 - 64) & 3)) / 4 - 1, 128 / 8);
        wr(12'h010, gdc(1'b0, 1'b0));
        got.delete();
        pulse();
        repeat (4) @(posedge pclk);
        chk({busy, overlay_on, 30'(got.size())}, 32'h0);
        final_report();
    end
endmodule : test_overlay_window_geometry
